// ---- verilog/ext_irq_pkg.sv ----
// Package for the external interrupt latch: control word, status word, constants.
// Assumes a single system clock domain and an active-low interrupt pin.
package ext_irq_pkg;
    localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFA;
    localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFB;
    localparam logic RESET_LEVEL_MODE = 1'h0;
    localparam logic RESET_GATE = 1'h0;
    localparam logic RESET_PIN_SAMPLE = 1'h1;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic levelMode;   // Sensitivity select: 1 = edge plus low level
        logic requestGate; // Request gate bit: 1 withholds the request
        logic ackWrite;    // One-cycle software acknowledge strobe
    } ctrl_t;

    typedef struct packed {
        logic pendingFlag; // Request pending, gate ignored
        logic ackReadBack; // Acknowledge bit, always reads zero
        logic requestGate;
        logic levelMode;
    } status_t;
endpackage

// ---- verilog/external_interrupt_latch.sv ----
// External interrupt latch for an active-low pin.
// Assumes the pin is asynchronous and the processor core supplies vector fetch strobes.
`timescale 1ns/1ns
module external_interrupt_latch (
    input wire logic sys_clk,                     // 250 MHz system clock
    input wire logic sys_rst,                     // Async reset, active high
    input wire logic irqPin_n,                    // External interrupt pin, active low
    input wire ext_irq_pkg::ctrl_t ctrlIn,        // Software control and acknowledge
    input wire logic vectorFetch,                 // Core fetching this vector, one cycle
    input wire logic globalMask,                  // Core global interrupt mask
    output ext_irq_pkg::status_t statusOut,       // Status and control read-back
    output logic irqRequest,                      // Request to priority logic
    output logic serviceReq,                      // Request the core may service now
    output logic pinLevel,                        // Synchronised pin level for branches
    output logic [15:0] vectorAddr                // Vector address for service
);
    import ext_irq_pkg::*;

    logic [SYNC_STAGES-1:0] pinSync_q;
    logic pinStable_q;
    logic latch_q;
    logic levelMode_q;
    logic gate_q;
    logic ackSeen_q;
    logic fallEdge;
    logic ackEvent;
    logic pinHighNow;

    // Level mode release: acknowledge seen and pin back high
    function automatic logic levelRelease(input logic pinHigh, input logic ackNow,
            input logic ackHeld);
        levelRelease = pinHigh & (ackNow | ackHeld);
    endfunction

    genvar stage;
    generate
        for (stage = 0; stage < SYNC_STAGES; stage++) begin : g_sync
            if (stage == 0) begin : g_first
                always_ff @(posedge sys_clk or posedge sys_rst) begin
                    if (sys_rst) begin
                        pinSync_q[stage] <= RESET_PIN_SAMPLE;
                    end else begin
                        pinSync_q[stage] <= irqPin_n;
                    end
                end
            end else begin : g_next
                always_ff @(posedge sys_clk or posedge sys_rst) begin
                    if (sys_rst) begin
                        pinSync_q[stage] <= RESET_PIN_SAMPLE;
                    end else begin
                        pinSync_q[stage] <= pinSync_q[stage-1];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinStable_q <= RESET_PIN_SAMPLE;
        end else if (pinSync_q[1] == pinSync_q[2]) begin
            pinStable_q <= pinSync_q[2];
        end
    end

    assign pinHighNow = (pinSync_q[1] == pinSync_q[2]) ? pinSync_q[2] : pinStable_q;
    assign fallEdge = pinStable_q & ~pinHighNow;
    assign ackEvent = vectorFetch | ctrlIn.ackWrite;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            levelMode_q <= RESET_LEVEL_MODE;
            gate_q <= RESET_GATE;
        end else begin
            levelMode_q <= ctrlIn.levelMode;
            gate_q <= ctrlIn.requestGate;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackSeen_q <= 1'h0;
        end else if (fallEdge || pinHighNow || !latch_q) begin
            ackSeen_q <= 1'h0;
        end else if (ackEvent && levelMode_q) begin
            ackSeen_q <= 1'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            latch_q <= 1'h0;
        end else if (fallEdge) begin
            latch_q <= 1'h1;
        end else if (levelMode_q && !pinHighNow) begin
            // Low level keeps the request alive in level mode
            latch_q <= 1'h1;
        end else if (!levelMode_q && ackEvent) begin
            latch_q <= 1'h0;
        end else if (levelMode_q && levelRelease(pinHighNow, ackEvent, ackSeen_q)) begin
            latch_q <= 1'h0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            statusOut <= '0;
            irqRequest <= 1'h0;
            serviceReq <= 1'h0;
            pinLevel <= RESET_PIN_SAMPLE;
            vectorAddr <= 16'h0000;
        end else begin
            statusOut.pendingFlag <= latch_q;
            statusOut.ackReadBack <= 1'h0;
            statusOut.requestGate <= gate_q;
            statusOut.levelMode <= levelMode_q;
            irqRequest <= latch_q & ~gate_q;
            serviceReq <= latch_q & ~gate_q & ~globalMask;
            pinLevel <= pinHighNow;
            vectorAddr <= VECTOR_HI_ADDR;
        end
    end

    sequence s_edge_ungated;
        fallEdge ##1 (latch_q && !gate_q);
    endsequence

    sequence s_level_ack_low;
        levelMode_q && latch_q && ackEvent && !pinHighNow && !fallEdge;
    endsequence

    sequence s_level_ready;
        levelMode_q && latch_q && pinHighNow && ackSeen_q;
    endsequence

    a_edge_sets: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        fallEdge
        |=> latch_q)
        else $error("edge did not set latch");

    a_edge_ack_clears: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!levelMode_q && ackEvent && !fallEdge)
        |=> !latch_q)
        else $error("ack missed");

    a_level_holds: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (levelMode_q && latch_q && !pinHighNow)
        |=> latch_q)
        else $error("level dropped");

    a_gate_blocks: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (gate_q && latch_q)
        |=> !irqRequest)
        else $error("gate ignored");

    a_global_mask: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        globalMask
        |=> !serviceReq)
        else $error("global mask ignored");

    a_flag_tracks: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        latch_q
        |=> statusOut.pendingFlag)
        else $error("flag wrong");

    a_ack_zero: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        1'b1
        |-> !statusOut.ackReadBack)
        else $error("ack read nonzero");

    a_edge_stays: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!levelMode_q && latch_q && !ackEvent)
        |=> latch_q)
        else $error("latch lost");

    a_level_sets: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (levelMode_q && !pinHighNow)
        |=> latch_q)
        else $error("low level not latched");

    a_edge_request: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_edge_ungated
        |=> irqRequest)
        else $error("edge not presented");

    a_ack_remembered: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_level_ack_low
        |=> ackSeen_q)
        else $error("level ack lost");

    a_level_ready: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_level_ready
        |=> !latch_q)
        else $error("level latch not released");

    a_level_release: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (levelMode_q && latch_q && levelRelease(pinHighNow, ackEvent, ackSeen_q))
        |=> !latch_q)
        else $error("level release missed");

    a_ack_seen_clear: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        pinHighNow
        |=> !ackSeen_q)
        else $error("stale level ack");

    a_edge_no_level: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!levelMode_q && !latch_q && !fallEdge)
        |=> !latch_q)
        else $error("latch set without edge");

    a_set_wins: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (fallEdge && ackEvent)
        |=> latch_q)
        else $error("edge lost to ack");

    a_flag_clears: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !latch_q
        |=> !statusOut.pendingFlag)
        else $error("flag stuck");

    a_flag_gated: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (gate_q && latch_q)
        |=> statusOut.pendingFlag)
        else $error("flag hidden by gate");

    a_request_open: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (latch_q && !gate_q)
        |=> irqRequest)
        else $error("request not presented");

    a_service_open: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (latch_q && !gate_q && !globalMask)
        |=> serviceReq)
        else $error("service not offered");

    a_service_subset: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        serviceReq
        |-> irqRequest)
        else $error("service without request");

    a_vector_addr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        irqRequest
        |-> (vectorAddr == VECTOR_HI_ADDR))
        else $error("wrong vector");

    a_pin_level: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        1'b1
        |=> (pinLevel == $past(pinHighNow)))
        else $error("pin level stale");

    a_sync_agree: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        fallEdge
        |-> (pinSync_q[1] == pinSync_q[2]))
        else $error("edge without agreement");

    a_reset_clears: assert property (
        @(posedge sys_clk)
        ($past(sys_rst) && sys_rst)
        |-> (!latch_q && !levelMode_q && !statusOut.pendingFlag))
        else $error("reset left state");
endmodule

// ---- tb/pin_source.sv ----
// Model of the outside source on the active-low interrupt pin.
// Assumes the bench steers it through driveLow; released pin is pulled up.
`timescale 1ns/1ns
module pin_source (
    input wire logic sys_clk, // System clock
    input wire logic driveLow, // Pull the pin low when set
    output logic irqPin_n // Interrupt pin, active low
);
    initial irqPin_n = 1'b1;
    always @(posedge sys_clk) begin
        irqPin_n <= ~driveLow;
    end
endmodule

// ---- tb/external_interrupt_latch_tb.sv ----
// Self-checking bench for the external interrupt latch.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
module external_interrupt_latch_tb;
    import ext_irq_pkg::*;
    logic sys_clk = 0, sys_rst = 1, driveLow = 0, vectorFetch = 0, globalMask = 0;
    logic irqPin_n, irqRequest, serviceReq, pinLevel;
    logic [15:0] vectorAddr;
    ctrl_t ctrlIn = '0;
    status_t statusOut;
    int n_mismatch = 0, check_count = 0;
    pin_source u_pin_source(.sys_clk(sys_clk), .driveLow(driveLow), .irqPin_n(irqPin_n));
    external_interrupt_latch u_external_interrupt_latch(.sys_clk(sys_clk),
        .sys_rst(sys_rst), .irqPin_n(irqPin_n), .ctrlIn(ctrlIn), .vectorFetch(vectorFetch),
        .globalMask(globalMask), .statusOut(statusOut), .irqRequest(irqRequest),
        .serviceReq(serviceReq), .pinLevel(pinLevel), .vectorAddr(vectorAddr));
    initial forever #2 sys_clk = ~sys_clk;
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic waitFlag(input logic exp);
        #1;
        for (int i = 0; i < 12 && statusOut.pendingFlag !== exp; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(statusOut.pendingFlag === exp, "pending flag");
        if (statusOut.pendingFlag !== exp) summarize();
    endtask
    // One-cycle acknowledge: vector fetch or software write
    task automatic ack(input bit vf);
        @(posedge sys_clk);
        if (vf) vectorFetch <= 1'b1;
        else ctrlIn.ackWrite <= 1'b1;
        @(posedge sys_clk);
        vectorFetch <= 1'b0;
        ctrlIn.ackWrite <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic pinTo(input logic low);
        @(posedge sys_clk);
        driveLow <= low;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic edgeMode();
        pinTo(1); waitFlag(1);
        chk(irqRequest === 1'b1 && statusOut.ackReadBack === 1'b0, "request");
        chk(vectorAddr === VECTOR_HI_ADDR && pinLevel === 1'b0, "vector or pin");
        ack(0); waitFlag(0);
        pinTo(0); pinTo(1); waitFlag(1);
        ack(1); waitFlag(0);
        pinTo(0);
    endtask
    task automatic gating();
        ctrlIn.requestGate <= 1'b1;
        pinTo(1);
        waitFlag(1);
        chk(irqRequest === 1'b0, "gate held");
        @(posedge sys_clk);
        ctrlIn.requestGate <= 1'b0;
        globalMask <= 1'b1;
        pinTo(0);
        #1;
        chk(irqRequest === 1'b1 && serviceReq === 1'b0, "global mask");
        @(posedge sys_clk);
        globalMask <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(serviceReq === 1'b1 && pinLevel === 1'b1, "service open");
        ack(0);
    endtask
    task automatic levelMode();
        // level use: caller leaves gate and global mask clear
        ctrlIn.levelMode <= 1'b1;
        pinTo(1);
        waitFlag(1);
        ack(0);
        repeat (6) @(posedge sys_clk);
        #1;
        chk(statusOut.pendingFlag === 1'b1, "held while low");
        pinTo(0);
        waitFlag(0);
        pinTo(1);
        waitFlag(1);
        @(posedge sys_clk);
        ctrlIn <= '0;
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(statusOut.pendingFlag === 1'b0 && statusOut.levelMode === 1'b0, "reset");
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        pinTo(0);
        ack(0);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        edgeMode();
        gating();
        levelMode();
        summarize();
    end
endmodule
